// ===== hw/csf_params.svh
// Offsets, field positions, reset values and timing counts of the status flag bank
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

`define CSF_ADDR_W 8
`define CSF_OFS_FLAGS 8'h00
`define CSF_OFS_CTRL 8'h04
`define CSF_OFS_PERIOD 8'h08
`define CSF_OFS_IRQ_STAT 8'h0C
`define CSF_OFS_IRQ_MASK 8'h10

`define CSF_B_FIRST 0
`define CSF_B_ANYF 1
`define CSF_B_INF 2
`define CSF_B_OUTF 3
`define CSF_B_EJECT 4
`define CSF_B_ARITH 5
`define CSF_B_OVRUN 6
`define CSF_B_INDEX 7

`define CSF_B_PERIODIC 0

`define CSF_IRQ_N 4
`define CSF_IRQ_ARITH 0
`define CSF_IRQ_OVRUN 1
`define CSF_IRQ_INDEX 2
`define CSF_IRQ_FIRST 3

`define CSF_RST_FLAGS 8'h00
`define CSF_RST_CTRL 1'b0
`define CSF_RST_PERIOD 16'h0000
`define CSF_RST_MASK 4'h0

`define CSF_S16_MAX 64'sh0000_0000_0000_7FFF
`define CSF_S16_MIN 64'shFFFF_FFFF_FFFF_8000
`define CSF_S32_MAX 64'sh0000_0000_7FFF_FFFF
`define CSF_S32_MIN 64'shFFFF_FFFF_8000_0000
`define CSF_FLT_MAX_BITS 63'h47EF_FFFF_E000_0000
`define CSF_BCD_MAX 64'sh0000_0000_0000_270F

`define CSF_CLK_HZ 25000000
`define CSF_TICK_US 1000
`define CSF_TICK_CYCLES (`CSF_CLK_HZ / 1000000 * `CSF_TICK_US)

`endif

// ===== hw/csf_pkg.sv
// Types shared by the status flag bank
package csf_pkg;
	typedef enum logic [2:0] {
		CSF_OP_SINGLE,
		CSF_OP_DOUBLE,
		CSF_OP_FLOAT,
		CSF_OP_DIV,
		CSF_OP_SQRT,
		CSF_OP_BCD_TO_INT,
		CSF_OP_INT_TO_BCD,
		CSF_OP_NONE
	} csf_op_t;

	typedef enum logic [0:0] {
		CSF_BUS_IDLE,
		CSF_BUS_ACK
	} csf_bus_t;
endpackage : csf_pkg

// ===== hw/csf_sticky.sv
// One sticky flag bit whose hardware set wins over a clear
`timescale 1ns/1ns
`default_nettype none
module csf_sticky (
	input wire logic clk,
	input wire logic reset,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	logic q_r;
	logic q_nxt;

	assign q_nxt = set ? 1'b1 : (clr ? 1'b0 : q_r);
	assign q = q_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			q_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end
endmodule : csf_sticky
`default_nettype wire

// ===== hw/csf_flag_bank.sv
// Controller status flag bank with Avalon-MM register access
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "csf_params.svh"

// What this block does
// RULE1: First-run flag high during first running scan
// RULE2: Any-force flag is input or output forced
// RULE3: Input-forced flag high while any input forced
// RULE4: Output-forced flag high while any output forced
// RULE5: Ejected bit follows last shift, software writable
// RULE6: Single-length result outside 16-bit range sets error
// RULE7: Double-length result outside 32-bit range sets error
// RULE8: Float magnitude beyond single maximum sets error
// RULE9: Divide by zero, negative root, bad BCD
// RULE10: Arithmetic error sticky until program writes zero
// RULE11: Periodic scan longer than period sets overrun; the code never sets it with a zero period setting or on a scan_end cycle
// RULE12: Only program clears overrun, by writing zero
// RULE13: Index outside zero to maximum sets overflow
// RULE14: Program tests index overflow, clears with zero
// RULE15: Hardware set beats same-cycle program clear
module csf_flag_bank import csf_pkg::*; #(
	parameter int N_IN = 16,
	parameter int N_OUT = 16,
	parameter int TICK_CYCLES = `CSF_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [`CSF_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic controller_running,
	input wire logic scan_start,
	input wire logic scan_end,
	input wire logic [N_IN-1:0] input_force_mask,
	input wire logic [N_OUT-1:0] output_force_mask,
	input wire logic shift_valid,
	input wire logic shift_out_bit,
	input wire logic arith_valid,
	input wire csf_op_t arith_op,
	input wire logic [63:0] arith_value,
	input wire logic index_valid,
	input wire logic [31:0] index_addr,
	input wire logic [31:0] index_limit,
	output logic first_run_scan_flag,
	output logic any_force_active_flag,
	output logic input_forced_flag,
	output logic output_forced_flag,
	output logic ejected_bit_flag,
	output logic arith_error_flag,
	output logic scan_overrun_flag,
	output logic index_overflow_flag
);
	localparam int TCW = $clog2(TICK_CYCLES + 1);

	// Bus slave state
	csf_bus_t bus_r;
	csf_bus_t bus_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	// Software-visible control
	logic periodic_r;
	logic [15:0] scan_period_setting_r;
	logic [`CSF_IRQ_N-1:0] irq_mask_r;
	logic [`CSF_IRQ_N-1:0] irq_stat;

	// Flag state
	logic first_r;
	logic first_nxt;
	logic run_pend_r;
	logic run_pend_nxt;
	logic run_d_r;
	logic in_force_r;
	logic out_force_r;
	logic eject_r;
	logic eject_nxt;

	// Scan timing
	logic in_scan_r;
	logic [TCW-1:0] tick_cnt_r;
	logic [15:0] ms_cnt_r;
	logic overrun_done_r;

	// Bus decode
	wire req = avs_read | avs_write;
	wire ack = (bus_r == CSF_BUS_ACK);
	wire wr_ack = ack & avs_write;
	wire be0 = avs_byteenable[0];
	wire be1 = avs_byteenable[1];
	wire sel_flags = (avs_address == `CSF_OFS_FLAGS);
	wire sel_ctrl = (avs_address == `CSF_OFS_CTRL);
	wire sel_period = (avs_address == `CSF_OFS_PERIOD);
	wire sel_istat = (avs_address == `CSF_OFS_IRQ_STAT);
	wire sel_imask = (avs_address == `CSF_OFS_IRQ_MASK);
	wire wr_flags = wr_ack & sel_flags & be0;
	wire wr_ctrl = wr_ack & sel_ctrl & be0;
	wire wr_period_lo = wr_ack & sel_period & be0;
	wire wr_period_hi = wr_ack & sel_period & be1;
	wire wr_istat = wr_ack & sel_istat & be0;
	wire wr_imask = wr_ack & sel_imask & be0;

	// Program clears of sticky flags: writing zero clears
	wire clr_arith = wr_flags & ~avs_writedata[`CSF_B_ARITH]; // RULE10
	wire clr_ovrun = wr_flags & ~avs_writedata[`CSF_B_OVRUN]; // RULE12
	wire clr_index = wr_flags & ~avs_writedata[`CSF_B_INDEX]; // RULE14

	// Arithmetic checks on the reported result or operand
	wire signed [63:0] aval = arith_value;
	wire single_ovf = (aval > `CSF_S16_MAX) | (aval < `CSF_S16_MIN); // RULE6
	wire double_ovf = (aval > `CSF_S32_MAX) | (aval < `CSF_S32_MIN); // RULE7
	wire float_ovf = (arith_value[62:0] > `CSF_FLT_MAX_BITS); // RULE8
	wire div_zero = (arith_value == 64'h0000_0000_0000_0000); // RULE9
	wire sqrt_neg = aval[63]; // RULE9
	wire bcd_bad = (arith_value[3:0] > 4'h9) | (arith_value[7:4] > 4'h9) |
		(arith_value[11:8] > 4'h9) | (arith_value[15:12] > 4'h9) |
		(arith_value[63:16] != 48'h0000_0000_0000); // RULE9
	wire itb_bad = aval[63] | (aval > `CSF_BCD_MAX); // RULE9
	logic arith_hit;
	always_comb begin
		case (arith_op)
			CSF_OP_SINGLE: arith_hit = single_ovf;
			CSF_OP_DOUBLE: arith_hit = double_ovf;
			CSF_OP_FLOAT: arith_hit = float_ovf;
			CSF_OP_DIV: arith_hit = div_zero;
			CSF_OP_SQRT: arith_hit = sqrt_neg;
			CSF_OP_BCD_TO_INT: arith_hit = bcd_bad;
			CSF_OP_INT_TO_BCD: arith_hit = itb_bad;
			default: arith_hit = 1'b0;
		endcase
	end
	wire set_arith = arith_valid & arith_hit;

	// Index range check
	wire set_index = index_valid & (index_addr[31] | (index_addr > index_limit)); // RULE13

	// Scan period watch: elapsed milliseconds beyond the period
	wire tick = (tick_cnt_r == TCW'(TICK_CYCLES - 1));
	wire period_hit = in_scan_r & tick & ({1'b0, ms_cnt_r} + 17'h0_0001 > {1'b0, scan_period_setting_r});
	wire set_ovrun = periodic_r & ~overrun_done_r & ~scan_end &
		(scan_period_setting_r != 16'h0000) & period_hit; // RULE11

	// First scan after entering running state
	wire run_rise = controller_running & ~run_d_r;
	always_comb begin
		first_nxt = first_r;
		run_pend_nxt = run_pend_r | run_rise;
		if (!controller_running) begin
			first_nxt = 1'b0;
			run_pend_nxt = 1'b0;
		end else if (scan_start) begin
			first_nxt = run_pend_r | run_rise; // RULE1
			run_pend_nxt = 1'b0;
		end
	end
	wire first_rise = first_nxt & ~first_r;

	// Ejected bit: shift result wins over program write
	always_comb begin
		eject_nxt = eject_r;
		if (shift_valid) begin
			eject_nxt = shift_out_bit; // RULE5
		end else if (wr_flags) begin
			eject_nxt = avs_writedata[`CSF_B_EJECT]; // RULE5
		end
	end

	// Sticky flags, set beats clear inside each cell
	csf_sticky u_arith (
		.clk(clk),
		.reset(reset),
		.set(set_arith), // RULE15
		.clr(clr_arith),
		.q(arith_error_flag)
	);
	csf_sticky u_ovrun (
		.clk(clk),
		.reset(reset),
		.set(set_ovrun), // RULE15
		.clr(clr_ovrun),
		.q(scan_overrun_flag)
	);
	csf_sticky u_index (
		.clk(clk),
		.reset(reset),
		.set(set_index), // RULE15
		.clr(clr_index),
		.q(index_overflow_flag)
	);

	// Interrupt status, write one to clear
	wire [`CSF_IRQ_N-1:0] irq_set = {first_rise, set_index, set_ovrun, set_arith};
	genvar gi;
	generate
		for (gi = 0; gi < `CSF_IRQ_N; gi++) begin : g_irq
			csf_sticky u_irq (
				.clk(clk),
				.reset(reset),
				.set(irq_set[gi]),
				.clr(wr_istat & avs_writedata[gi]),
				.q(irq_stat[gi])
			);
		end
	endgenerate
	assign irq = |(irq_stat & irq_mask_r);

	// Flag outputs
	assign first_run_scan_flag = first_r;
	assign input_forced_flag = in_force_r;
	assign output_forced_flag = out_force_r;
	assign any_force_active_flag = in_force_r | out_force_r; // RULE2
	assign ejected_bit_flag = eject_r;

	wire [7:0] flags_word = {index_overflow_flag, scan_overrun_flag, arith_error_flag,
		eject_r, out_force_r, in_force_r, any_force_active_flag, first_r};

	// Read mux, unmapped reads return zero
	always_comb begin
		case (1'b1)
			sel_flags: rdata_nxt = {24'h00_0000, flags_word};
			sel_ctrl: rdata_nxt = {31'h0000_0000, periodic_r};
			sel_period: rdata_nxt = {16'h0000, scan_period_setting_r};
			sel_istat: rdata_nxt = {28'h000_0000, irq_stat};
			sel_imask: rdata_nxt = {28'h000_0000, irq_mask_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// One wait cycle per access
	always_comb begin
		case (bus_r)
			CSF_BUS_IDLE: bus_nxt = req ? CSF_BUS_ACK : CSF_BUS_IDLE;
			CSF_BUS_ACK: bus_nxt = CSF_BUS_IDLE;
			default: bus_nxt = CSF_BUS_IDLE;
		endcase
	end
	assign avs_waitrequest = ~ack;
	assign avs_readdata = rdata_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_r <= CSF_BUS_IDLE;
			rdata_r <= 32'h0000_0000;
		end else begin
			bus_r <= bus_nxt;
			if (bus_r == CSF_BUS_IDLE && avs_read) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			periodic_r <= `CSF_RST_CTRL;
			scan_period_setting_r <= `CSF_RST_PERIOD;
			irq_mask_r <= `CSF_RST_MASK;
		end else begin
			if (wr_ctrl) begin
				periodic_r <= avs_writedata[`CSF_B_PERIODIC];
			end
			if (wr_period_lo) begin
				scan_period_setting_r[7:0] <= avs_writedata[7:0];
			end
			if (wr_period_hi) begin
				scan_period_setting_r[15:8] <= avs_writedata[15:8];
			end
			if (wr_imask) begin
				irq_mask_r <= avs_writedata[`CSF_IRQ_N-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			first_r <= 1'b0;
			run_pend_r <= 1'b0;
			run_d_r <= 1'b0;
			in_force_r <= 1'b0;
			out_force_r <= 1'b0;
			eject_r <= 1'b0;
		end else begin
			first_r <= first_nxt; // RULE1
			run_pend_r <= run_pend_nxt;
			run_d_r <= controller_running;
			in_force_r <= |input_force_mask; // RULE3
			out_force_r <= |output_force_mask; // RULE4
			eject_r <= eject_nxt;
		end
	end

	// Scan length in milliseconds, restarted at each scan start
	always_ff @(posedge clk) begin
		if (reset) begin
			in_scan_r <= 1'b0;
			tick_cnt_r <= '0;
			ms_cnt_r <= 16'h0000;
			overrun_done_r <= 1'b0;
		end else if (scan_start) begin
			in_scan_r <= 1'b1;
			tick_cnt_r <= '0;
			ms_cnt_r <= 16'h0000;
			overrun_done_r <= 1'b0;
		end else if (scan_end) begin
			in_scan_r <= 1'b0;
		end else if (in_scan_r) begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + TCW'(1);
			if (tick && ms_cnt_r != 16'hFFFF) begin
				ms_cnt_r <= ms_cnt_r + 16'h0001;
			end
			if (set_ovrun) begin
				overrun_done_r <= 1'b1; // RULE11
			end
		end
	end
endmodule : csf_flag_bank
`default_nettype wire

// ===== sim/csf_flag_bank_props.sv
// Port assertions and covers for the status flag bank
`timescale 1ns/1ns
`default_nettype none
module csf_flag_bank_props import csf_pkg::*; #(
	parameter int N_IN = 16,
	parameter int N_OUT = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic [N_IN-1:0] input_force_mask,
	input wire logic [N_OUT-1:0] output_force_mask,
	input wire logic shift_valid,
	input wire logic shift_out_bit,
	input wire logic arith_valid,
	input wire csf_op_t arith_op,
	input wire logic [63:0] arith_value,
	input wire logic index_valid,
	input wire logic [31:0] index_addr,
	input wire logic first_run_scan_flag,
	input wire logic any_force_active_flag,
	input wire logic input_forced_flag,
	input wire logic output_forced_flag,
	input wire logic ejected_bit_flag,
	input wire logic arith_error_flag,
	input wire logic scan_overrun_flag,
	input wire logic index_overflow_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Accepted write to the flag word
	wire clr_w = avs_write && !avs_waitrequest && avs_address == 8'h00;
	wire signed [63:0] v = arith_value;
	a_any_force: assert property (any_force_active_flag == (input_forced_flag | output_forced_flag))
		else $error("any force flag wrong");
	a_in_forced: assert property (!$past(reset) |-> input_forced_flag == $past(|input_force_mask))
		else $error("input forced flag wrong");
	a_out_forced: assert property (!$past(reset) |-> output_forced_flag == $past(|output_force_mask))
		else $error("output forced flag wrong");
	a_eject_shift: assert property (shift_valid |=> ejected_bit_flag == $past(shift_out_bit))
		else $error("ejected bit wrong");
	a_single_ovf: assert property (arith_valid && arith_op == CSF_OP_SINGLE && (v > 64'sh7FFF || v < -64'sh8000)
		|=> arith_error_flag) else $error("single overflow missed");
	a_double_ovf: assert property (arith_valid && arith_op == CSF_OP_DOUBLE
		&& (v > 64'sh7FFF_FFFF || v < -64'sh8000_0000) |=> arith_error_flag)
		else $error("double overflow missed");
	a_div_zero: assert property (arith_valid && arith_op == CSF_OP_DIV && v == 64'sh0 |=> arith_error_flag)
		else $error("divide by zero missed");
	a_arith_hold: assert property (arith_error_flag && !(clr_w && !avs_writedata[5]) |=> arith_error_flag)
		else $error("arith error dropped");
	a_ovrun_hold: assert property (scan_overrun_flag && !(clr_w && !avs_writedata[6]) |=> scan_overrun_flag)
		else $error("overrun dropped");
	a_index_neg: assert property (index_valid && index_addr[31] |=> index_overflow_flag)
		else $error("negative index missed");
	cover property (first_run_scan_flag);
	cover property (scan_overrun_flag && irq);
	cover property (index_overflow_flag);
endmodule : csf_flag_bank_props
bind csf_flag_bank csf_flag_bank_props #(.N_IN(N_IN), .N_OUT(N_OUT)) csf_flag_bank_props_i (.*);
`default_nettype wire

// ===== sim/csf_flag_bank_test.sv
// Self-checking bench for the status flag bank
`timescale 1ns/1ns
`default_nettype none
module csf_flag_bank_test import csf_pkg::*;;
	logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, running = 0, scan_start = 0, scan_end = 0;
	logic shift_valid = 0, shift_out_bit = 0, arith_valid = 0, index_valid = 0, avs_waitrequest, irq;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, index_addr = 32'h0, avs_readdata, rdata;
	logic [15:0] in_m = 16'h0, out_m = 16'h0;
	csf_op_t arith_op = CSF_OP_NONE;
	logic [63:0] arith_value = 64'h0;
	wire [7:0] fl;
	int n_mismatch = 0, n_tests = 0;
	localparam int P_SHIFT = 0, P_ARITH = 1, P_INDEX = 2, P_START = 3, P_END = 4;
	csf_flag_bank #(.TICK_CYCLES(10)) csf_flag_bank_i (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.controller_running(running), .scan_start(scan_start), .scan_end(scan_end),
		.input_force_mask(in_m), .output_force_mask(out_m), .shift_valid(shift_valid),
		.shift_out_bit(shift_out_bit), .arith_valid(arith_valid), .arith_op(arith_op),
		.arith_value(arith_value), .index_valid(index_valid), .index_addr(index_addr),
		.index_limit(32'h0000_0010), .first_run_scan_flag(fl[0]), .any_force_active_flag(fl[1]),
		.input_forced_flag(fl[2]), .output_forced_flag(fl[3]), .ejected_bit_flag(fl[4]),
		.arith_error_flag(fl[5]), .scan_overrun_flag(fl[6]), .index_overflow_flag(fl[7]));
	initial forever #20 clk = ~clk;
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		#1;
	endtask : acc
	task pulse(input int k);
		@(posedge clk);
		case (k)
			P_SHIFT: shift_valid <= 1'b1;
			P_ARITH: arith_valid <= 1'b1;
			P_INDEX: index_valid <= 1'b1;
			P_START: scan_start <= 1'b1;
			P_END: scan_end <= 1'b1;
			default: ;
		endcase
		@(posedge clk);
		{shift_valid, arith_valid, index_valid, scan_start, scan_end} <= 5'h00;
		#1;
	endtask : pulse
	task frc(input logic [15:0] i, o, input logic [2:0] e);
		@(posedge clk);
		in_m <= i;
		out_m <= o;
		repeat (2) @(posedge clk);
		#1 chk(fl[3:1], e);
	endtask : frc
	task ar(input csf_op_t op, input logic [63:0] v, input logic e);
		@(posedge clk);
		arith_op <= op;
		arith_value <= v;
		pulse(P_ARITH);
		chk(fl[5], e);
		acc(1'b1, 8'h00, 32'h0);
	endtask : ar
	task ix(input logic [31:0] a, input logic e);
		@(posedge clk);
		index_addr <= a;
		pulse(P_INDEX);
		chk(fl[7], e);
		acc(1'b1, 8'h00, 32'h0);
	endtask : ix
	task t_reset;
		chk(fl, 8'h00);
		acc(1'b0, 8'h00, 32'h0);
		chk(rdata, 32'h0);
		acc(1'b0, 8'h40, 32'h0);
		chk(rdata, 32'h0);
	endtask : t_reset
	task t_misc;
		frc(16'h8000, 16'h0, 3'b011);
		frc(16'h0, 16'h0001, 3'b101);
		frc(16'h0, 16'h0, 3'b000);
		@(posedge clk);
		shift_out_bit <= 1'b1;
		pulse(P_SHIFT);
		chk(fl[4], 1'b1);
		acc(1'b1, 8'h00, 32'h0);
		chk(fl[4], 1'b0);
		acc(1'b1, 8'h00, 32'h10);
		chk(fl[4], 1'b1);
	endtask : t_misc
	task t_arith;
		ar(CSF_OP_SINGLE, 64'h7FFF, 1'b0);
		ar(CSF_OP_SINGLE, 64'h8000, 1'b1);
		ar(CSF_OP_SINGLE, 64'hFFFF_FFFF_FFFF_7FFF, 1'b1);
		ar(CSF_OP_DOUBLE, 64'h7FFF_FFFF, 1'b0);
		ar(CSF_OP_DOUBLE, 64'hFFFF_FFFF_7FFF_FFFF, 1'b1);
		ar(CSF_OP_FLOAT, 64'h47EF_FFFF_E000_0000, 1'b0);
		ar(CSF_OP_FLOAT, 64'hC7EF_FFFF_E000_0001, 1'b1);
		ar(CSF_OP_DIV, 64'h0, 1'b1);
		ar(CSF_OP_SQRT, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1);
		ar(CSF_OP_BCD_TO_INT, 64'h000A, 1'b1);
		ar(CSF_OP_INT_TO_BCD, 64'h2710, 1'b1);
		ar(CSF_OP_DOUBLE, 64'h8000_0000, 1'b1);
		ar(CSF_OP_DIV, 64'h3, 1'b0);
		ar(CSF_OP_SQRT, 64'h4, 1'b0);
		ar(CSF_OP_BCD_TO_INT, 64'h9999, 1'b0);
		ar(CSF_OP_INT_TO_BCD, 64'h270F, 1'b0);
	endtask : t_arith
	task t_sticky;
		@(posedge clk);
		arith_op <= CSF_OP_SINGLE;
		arith_value <= 64'h8000;
		pulse(P_ARITH);
		acc(1'b1, 8'h00, 32'h20);
		chk(fl[5], 1'b1);
		// Set lands on the very edge at which the clearing write takes effect
		fork
			acc(1'b1, 8'h00, 32'h0);
			begin
				@(posedge clk);
				pulse(P_ARITH);
			end
		join
		chk(fl[5], 1'b1);
		acc(1'b1, 8'h00, 32'h0);
		chk(fl[5], 1'b0);
	endtask : t_sticky
	task t_scan;
		acc(1'b1, 8'h10, 32'hF);
		acc(1'b1, 8'h0C, 32'hF);
		acc(1'b1, 8'h04, 32'h1);
		acc(1'b1, 8'h08, 32'h1);
		acc(1'b0, 8'h08, 32'h0);
		chk(rdata, 32'h1);
		chk(irq, 1'b0);
		@(posedge clk);
		running <= 1'b1;
		pulse(P_START);
		chk({irq, fl[6], fl[0]}, 3'b101);
		acc(1'b1, 8'h0C, 32'h8);
		chk(irq, 1'b0);
		// One ms period: overrun shows at the second ms tick, 20 edges after start
		repeat (16) @(posedge clk);
		#1 chk({irq, fl[6], fl[0]}, 3'b001);
		@(posedge clk);
		#1 chk({irq, fl[6], fl[0]}, 3'b111);
		acc(1'b0, 8'h00, 32'h0);
		chk(rdata, 32'h41);
		acc(1'b1, 8'h10, 32'h0);
		chk(irq, 1'b0);
		pulse(P_END);
		pulse(P_START);
		chk(fl[0], 1'b0);
		acc(1'b1, 8'h00, 32'h40);
		chk(fl[6], 1'b1);
		pulse(P_END);
		acc(1'b1, 8'h00, 32'h0);
		chk(fl[6], 1'b0);
	endtask : t_scan
	task wrap_up;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_reset;
		t_misc;
		t_arith;
		t_sticky;
		t_scan;
		ix(32'hFFFF_FFFF, 1'b1);
		ix(32'h10, 1'b0);
		ix(32'h11, 1'b1);
		wrap_up;
	end
	initial begin
		#200000;
		n_mismatch++;
		wrap_up;
	end
endmodule : csf_flag_bank_test
`default_nettype wire
